// >>> rtl/psc_top.sv
// Positioning start command interpreter with APB registers
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "psc_cfg.svh"
module psc_top #(
  parameter int AXES          = `PSC_AXES,
  parameter int LAUNCH_CYCLES = `PSC_LAUNCH_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Host pins
  input  wire logic        controller_ready_output,
  input  wire logic        scan_end,
  output logic             completion_done,
  output logic             completion_error,
  // Motion core, same clock
  input  wire logic        module_ready_flag,
  input  wire logic [3:0]  motion_done,
  input  wire logic [3:0]  stop_request,
  output logic             launch_valid,
  output logic [1:0]       launch_axis,
  output psc_pkg::psc_kind_type launch_kind,
  output logic [15:0]      launch_number,
  output logic [3:0]       axis_start_input,
  output logic [3:0]       axis_start_complete_flag,
  output logic [3:0]       axis_busy_flag,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    // Command
    psc_pkg::psc_state_type state;
    psc_pkg::psc_kind_type  kind;
    logic [1:0]  axis;
    logic [15:0] selector;
    logic [15:0] result;
    logic        failed;
    // Launch divider
    logic [14:0] tick_cnt;
    logic        tick;
    // APB answer
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Completion and motion outputs
    logic        done;
    logic        error;
    logic        launch_valid;
    logic [3:0]  start_complete;
    logic [3:0]  busy;
    // Interrupt
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic        irq;
  } psc_top_type;

  psc_top_type r;
  psc_top_type next_r;

  // Synchronised host levels; both pins are asynchronous to clk
  logic ready_level;
  logic scan_rise;

  psc_sync u_ready_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (controller_ready_output),
    .level   (ready_level),
    .rise    ()
  );

  psc_sync u_scan_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pin     (scan_end),
    .level   (),
    .rise    (scan_rise)
  );

  // Sorts a start number into the kind of motion it asks for
  function automatic psc_pkg::psc_kind_type classify(input logic [15:0] num);
    if (num >= `PSC_DATA_LO && num <= `PSC_DATA_HI) begin
      classify = psc_pkg::psc_kind_data;
    end else if (num >= `PSC_BLOCK_LO && num <= `PSC_BLOCK_HI) begin
      classify = psc_pkg::psc_kind_block;
    end else if (num == `PSC_CODE_MOR) begin
      classify = psc_pkg::psc_kind_mor;
    end else if (num == `PSC_CODE_FOR) begin
      classify = psc_pkg::psc_kind_fast;
    end else if (num == `PSC_CODE_PVC) begin
      classify = psc_pkg::psc_kind_pvc;
    end else if (num == `PSC_CODE_MULTI) begin
      classify = psc_pkg::psc_kind_multi;
    end else begin
      classify = psc_pkg::psc_kind_bad;
    end
  endfunction

  // One divider period bounds the launch delay
  localparam logic [14:0] TICK_LAST = 15'(LAUNCH_CYCLES - 1);

  // Bus decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic [5:0]  idx;
  // Command request and completion events
  logic        go;
  logic        accept;
  logic [1:0]  go_axis;
  logic [1:0]  ev;
  logic [31:0] rdata;
  logic        hit;

  always_comb begin
    next_r = r;
    idx     = paddr[7:2];
    acc     = psel & penable & r.pready;
    wr      = acc & pwrite;
    rd      = acc & ~pwrite;
    go      = 1'b0;
    go_axis = pwdata[`PSC_CTRL_AXIS_LSB +: 2];
    ev      = 2'b00;
    rdata   = 32'h0000_0000;
    hit     = 1'b1;

    // One wait state: pready rises in the second access cycle
    next_r.pready  = psel & penable & ~r.pready;
    next_r.pslverr = 1'b0;
    next_r.launch_valid   = 1'b0;
    next_r.start_complete = 4'h0;

    // Read word of the addressed register
    unique case (idx)
      `PSC_IDX_SYSTEM:   rdata = 32'h0000_0000;
      `PSC_IDX_RESULT:   rdata = {16'h0000, r.result};
      `PSC_IDX_SELECTOR: rdata = {16'h0000, r.selector};
      `PSC_IDX_CONTROL:  rdata = {26'h000_0000, r.axis, 4'h0};
      `PSC_IDX_STATUS: begin
        rdata = {20'h0_0000,
                 r.busy,
                 1'b0,
                 r.state,
                 r.error,
                 r.done,
                 module_ready_flag,
                 ready_level};
      end
      `PSC_IDX_IRQ_STAT: rdata = {30'h0000_0000, r.irq_stat};
      `PSC_IDX_IRQ_MASK: rdata = {30'h0000_0000, r.irq_mask};
      default: begin
        hit = 1'b0;
      end
    endcase

    if (psel & penable & ~r.pready) begin
      // A write answers with zero so no stale register word shows on the bus
      if (pwrite) begin
        next_r.prdata = 32'h0000_0000;
      end else begin
        next_r.prdata = rdata;
      end
      next_r.pslverr = ~hit;
    end

    // Writes land at the edge where the master samples pready high
    if (wr) begin
      unique case (idx)
        `PSC_IDX_SELECTOR: next_r.selector = pwdata[15:0];
        `PSC_IDX_CONTROL:  go = pwdata[`PSC_CTRL_GO];
        `PSC_IDX_IRQ_MASK: next_r.irq_mask = pwdata[1:0];
        default: begin
        end
      endcase
    end

    // Both ready levels are needed; a refused request leaves no trace
    accept = go & module_ready_flag & ready_level;

    // Free-running divider: a launch waits for the next tick, hence 0 to one period late
    if (r.tick_cnt == TICK_LAST) begin
      next_r.tick_cnt = 15'h0000;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 15'h0001;
      next_r.tick     = 1'b0;
    end

    // Command sequencer
    unique case (r.state)
      psc_pkg::psc_idle: begin
        // Requests without both ready levels are dropped silently
        if (accept) begin
          next_r.axis = go_axis;
          next_r.kind = classify(r.selector);
          // The axis check wins over the number check
          if (32'(go_axis) >= AXES) begin
            next_r.result = `PSC_ERR_AXIS;
            next_r.failed = 1'b1;
            next_r.state  = psc_pkg::psc_report;
          end else if (classify(r.selector) == psc_pkg::psc_kind_bad) begin
            next_r.result = `PSC_ERR_NUMBER;
            next_r.failed = 1'b1;
            next_r.state  = psc_pkg::psc_report;
          end else begin
            next_r.failed = 1'b0;
            next_r.state  = psc_pkg::psc_wait_tick;
          end
        end
      end
      psc_pkg::psc_wait_tick: begin
        if (stop_request[r.axis]) begin
          // Stopped before the launch tick: nothing moved, the command still completes
          next_r.result = `PSC_RESULT_OK;
          next_r.state  = psc_pkg::psc_report;
        end else if (r.tick) begin
          // Launch goes to the motion core, never through the axis start inputs
          next_r.launch_valid             = 1'b1;
          next_r.start_complete[r.axis]   = 1'b1;
          next_r.busy[r.axis]             = 1'b1;
          next_r.state                    = psc_pkg::psc_run;
        end
      end
      psc_pkg::psc_run: begin
        // Finish and stop may be pulses; only this state looks at finish, stop is also seen in psc_wait_tick
        // Multi-axis start ends on the named axis only
        if (motion_done[r.axis] || stop_request[r.axis]) begin
          next_r.busy[r.axis] = 1'b0;
          next_r.result       = `PSC_RESULT_OK;
          next_r.state        = psc_pkg::psc_report;
        end
      end
      psc_pkg::psc_report: begin
        // Errors skip the launch and wait here for the scan end
        if (scan_rise) begin
          next_r.done  = 1'b1;
          next_r.error = r.failed;
          ev           = {r.failed, 1'b1};
          next_r.state = psc_pkg::psc_show;
        end
      end
      psc_pkg::psc_show: begin
        // Done and error fall together at the next scan end
        if (scan_rise) begin
          next_r.done  = 1'b0;
          next_r.error = 1'b0;
          next_r.state = psc_pkg::psc_idle;
        end
      end
      default: begin
        next_r.state = psc_pkg::psc_idle;
      end
    endcase

    // Read clears, but an event in the same cycle survives
    if (rd && idx == `PSC_IDX_IRQ_STAT) begin
      next_r.irq_stat = ev;
    end else begin
      next_r.irq_stat = r.irq_stat | ev;
    end
    next_r.irq      = |(next_r.irq_stat & r.irq_mask);
  end

  // Reset leaves the command idle with a zero result
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r          <= '0;
      r.state    <= psc_pkg::psc_idle;
      r.kind     <= psc_pkg::psc_kind_data;
      r.selector <= `PSC_SEL_RESET;
      r.result   <= `PSC_RESULT_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Every output but the start inputs is a register field; the start inputs stay tied low
  assign prdata                   = r.prdata;
  assign pready                   = r.pready;
  assign pslverr                  = r.pslverr;
  assign completion_done          = r.done;
  assign completion_error         = r.error;
  assign launch_valid             = r.launch_valid;
  assign launch_axis              = r.axis;
  assign launch_kind              = r.kind;
  assign launch_number            = r.selector;
  assign axis_start_input         = 4'h0;
  assign axis_start_complete_flag = r.start_complete;
  assign axis_busy_flag           = r.busy;
  assign irq                      = r.irq;

endmodule // psc_top

// >>> rtl/psc_cfg.svh
// Constants of the positioning start command block
// How it works
// - Start number 1..600 picks positioning data, 7000..7004 picks a block start.
// - Codes 9001..9004 launch machine origin return, fast return, value change, multi-axis.
// - Result word gets zero on success, nonzero error code on failure.
// - Axis field of the command picks axis one to four.
// - Done bit rises at end of the finishing scan, falls at the next one.
// - Error bit stays low on success, pulses with done bit on failure.
// - Command start never raises axis start inputs; start-complete pulse is brief.
// - Stop during motion ends the command and pulses done for one scan.
// - Command runs only while module ready; otherwise request is ignored.
// - Multi-axis start completes when the named axis finishes.
// - Launch may trail a dedicated start by 0 to 0.88 ms.
// - Start number out of range ends with error 1862H.
// - Axis beyond the fitted axis count ends with error 1865H.
// - Completion pair: done bit, plus error bit when completion failed.
`ifndef PSC_CFG_SVH
`define PSC_CFG_SVH

`define PSC_IDX_SYSTEM     6'h00
`define PSC_IDX_RESULT     6'h01
`define PSC_IDX_SELECTOR   6'h02
`define PSC_IDX_CONTROL    6'h04
`define PSC_IDX_STATUS     6'h05
`define PSC_IDX_IRQ_STAT   6'h06
`define PSC_IDX_IRQ_MASK   6'h07

`define PSC_CTRL_GO        0
`define PSC_CTRL_AXIS_LSB  4
`define PSC_SEL_RESET      16'h0000
`define PSC_RESULT_RESET   16'h0000
`define PSC_RESULT_OK      16'h0000
`define PSC_ERR_NUMBER     16'h1862
`define PSC_ERR_AXIS       16'h1865

`define PSC_DATA_LO        16'd1
`define PSC_DATA_HI        16'd600
`define PSC_BLOCK_LO       16'd7000
`define PSC_BLOCK_HI       16'd7004
`define PSC_CODE_MOR       16'd9001
`define PSC_CODE_FOR       16'd9002
`define PSC_CODE_PVC       16'd9003
`define PSC_CODE_MULTI     16'd9004

`define PSC_AXES           4
`define PSC_CLK_PERIOD_NS  50
`define PSC_LAUNCH_DELAY_NS 880000
`define PSC_LAUNCH_CYCLES  (`PSC_LAUNCH_DELAY_NS / `PSC_CLK_PERIOD_NS)

`endif

// >>> rtl/psc_pkg.sv
// Types of the positioning start command block
package psc_pkg;

  typedef enum logic [2:0] {
    psc_kind_data,
    psc_kind_block,
    psc_kind_mor,
    psc_kind_fast,
    psc_kind_pvc,
    psc_kind_multi,
    psc_kind_bad
  } psc_kind_type;

  typedef enum logic [2:0] {
    psc_idle,
    psc_wait_tick,
    psc_run,
    psc_report,
    psc_show
  } psc_state_type;

  typedef struct packed {
    logic [2:0] shift;
    logic       level;
    logic       rise;
  } psc_sync_type;

endpackage

// >>> rtl/psc_sync.sv
// Three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module psc_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Pin and filtered result
  input  wire logic pin,
  output logic      level,
  output logic      rise
);
  psc_pkg::psc_sync_type r;
  psc_pkg::psc_sync_type next_r;

  always_comb begin
    next_r       = r;
    next_r.shift = {r.shift[1:0], pin};
    next_r.rise  = 1'b0;
    // First stage feeds only the second; the filter looks at stages two and three
    if (r.shift[1] == r.shift[2]) begin
      next_r.level = r.shift[2];
      next_r.rise  = r.shift[2] & ~r.level;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign level = r.level;
  assign rise  = r.rise;
endmodule // psc_sync

// >>> tb/psc_checker.sv
// Port assertions for the positioning start command block
`timescale 1ns/1ps
module psc_checker (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // Bus and command outputs
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  completion_done,
  input wire logic                  completion_error,
  input wire logic                  launch_valid,
  input wire logic [1:0]            launch_axis,
  input wire psc_pkg::psc_kind_type launch_kind,
  input wire logic [3:0]            axis_start_input,
  input wire logic [3:0]            axis_start_complete_flag,
  input wire logic [3:0]            axis_busy_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence access_begins;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence one_wait_state;
    !pready ##1 pready;
  endsequence
  chk_apb_wait_state: assert property (access_begins |-> one_wait_state)
    else $error("pready not in second access cycle");
  chk_start_quiet: assert property (axis_start_input == 4'h0)
    else $error("axis start input raised");
  chk_launch_single: assert property (launch_valid |=> !launch_valid)
    else $error("launch longer than one cycle");
  chk_launch_flag: assert property (launch_valid |-> axis_start_complete_flag == 4'h1 << launch_axis)
    else $error("start complete on wrong axis");
  chk_busy_follows: assert property (launch_valid |=> axis_busy_flag[$past(launch_axis)])
    else $error("busy not set after launch");
  chk_kind_valid: assert property (launch_valid |-> launch_kind != psc_pkg::psc_kind_bad)
    else $error("launch of invalid number");
  chk_error_with_done: assert property (completion_error |-> completion_done)
    else $error("error bit without done bit");
  chk_done_holds: assert property ($rose(completion_done) |=> completion_done [*3])
    else $error("done bit too short");
endmodule // psc_checker

bind psc_top psc_checker u_psc_checker (
  .clk, .reset_n, .psel, .penable, .pready, .completion_done, .completion_error, .launch_valid,
  .launch_axis, .launch_kind, .axis_start_input, .axis_start_complete_flag, .axis_busy_flag
);

// >>> tb/psc_host_model.sv
// Host scan model: controller ready and end-of-scan pin
`timescale 1ns/1ps
module psc_host_model #(
  parameter int SCAN = 40
) (
  // Clock, reset and host pins
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      controller_ready_output,
  output logic      scan_end
);
  int cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      controller_ready_output <= 1'b0;
    end else begin
      cnt <= (cnt + 1) % SCAN;
      controller_ready_output <= 1'b1;
    end
  end
  // Half-period levels stay far longer than the pin filter needs
  assign scan_end = cnt >= SCAN / 2;
endmodule // psc_host_model

// >>> tb/tb_positioning_start_command.sv
// Self-checking bench for the positioning start command block
`timescale 1ns/1ps
module tb_positioning_start_command;
  localparam int SCAN = 40;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic                  module_ready_flag = 1'b1;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0000_0000;
  logic [3:0]            motion_done = 4'h0;
  logic [3:0]            stop_request = 4'h0;
  logic [1:0]            mask = 2'h3;
  logic                  pready, pslverr, serr, controller_ready_output, scan_end;
  logic                  completion_done, completion_error, launch_valid, irq;
  logic [31:0]           prdata, rd;
  logic [1:0]            launch_axis, l_axis;
  logic [15:0]           launch_number, l_num;
  logic [3:0]            axis_start_input, axis_start_complete_flag, axis_busy_flag, l_flag;
  psc_pkg::psc_kind_type launch_kind, l_kind;
  int                    err_count, comparisons, cycles, l_cnt, run_len, last_len;

  psc_top #(.AXES(3), .LAUNCH_CYCLES(8)) dut (
    .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .controller_ready_output, .scan_end, .completion_done, .completion_error, .module_ready_flag,
    .motion_done, .stop_request, .launch_valid, .launch_axis, .launch_kind, .launch_number,
    .axis_start_input, .axis_start_complete_flag, .axis_busy_flag, .irq
  );
  psc_host_model #(.SCAN(SCAN)) u_host (.clk, .reset_n, .controller_ready_output, .scan_end);

  initial begin
    forever #25 clk = ~clk;
  end

  // Launch pulses last one cycle, so they are captured here
  always @(posedge clk) begin
    cycles++;
    if (launch_valid === 1'b1) begin
      l_cnt++;
      l_axis = launch_axis;
      l_kind = launch_kind;
      l_num = launch_number;
      l_flag = axis_start_complete_flag;
    end
    if (completion_done === 1'b1) begin
      run_len++;
    end else if (run_len != 0) begin
      last_len = run_len;
      run_len = 0;
    end
    if (cycles == 10000) begin
      err_count++;
      results();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for pready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_done(logic v);
    while (completion_done !== v) begin
      @(posedge clk);
    end
  endtask

  task automatic fin(logic e, logic [15:0] res);
    int t;
    t = cycles;
    wait_done(1'b1);
    chk("done within a scan", 32'h0000_0001, 32'(cycles - t <= SCAN + 2));
    chk("error", 32'(e), 32'(completion_error));
    chk("busy cleared", 32'h0000_0000, 32'(axis_busy_flag));
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("result", 32'(res), rd);
    chk("irq", 32'(|(mask & {e, 1'b1})), 32'(irq));
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk("irq status", 32'({e, 1'b1}), rd);
    @(posedge clk);
    chk("irq cleared", 32'h0000_0000, 32'(irq));
    wait_done(1'b0);
    @(posedge clk);
    chk("done length", SCAN, last_len);
  endtask

  task automatic go(logic [1:0] ax, logic [15:0] num, psc_pkg::psc_kind_type k, logic stop);
    int c;
    c = l_cnt;
    apb(1'b1, 8'h08, 32'(num));
    apb(1'b1, 8'h10, 32'({ax, 4'h1}));
    repeat (12) @(posedge clk);
    chk("launched", c + 1, l_cnt);
    chk("axis", 32'(ax), 32'(l_axis));
    chk("kind", 32'(k), 32'(l_kind));
    chk("number", 32'(num), 32'(l_num));
    chk("start complete", 32'(4'h1 << ax), 32'(l_flag));
    chk("busy", 32'h0000_0001, 32'(axis_busy_flag[ax]));
    if (k == psc_pkg::psc_kind_multi) begin
      motion_done <= 4'h1 << (ax + 2'h1);
      @(posedge clk);
      motion_done <= 4'h0;
      repeat (2 * SCAN) @(posedge clk);
      chk("done from other axis", 32'h0000_0000, 32'(completion_done));
    end
    stop_request <= stop ? 4'h1 << ax : 4'h0;
    motion_done <= stop ? 4'h0 : 4'h1 << ax;
    @(posedge clk);
    stop_request <= 4'h0;
    motion_done <= 4'h0;
  endtask

  task automatic t_regs;
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      chk("reset value", 32'h0000_0000, rd);
    end
    apb(1'b1, 8'h04, 32'h0000_ffff);
    apb(1'b1, 8'h08, 32'h0000_1234);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("result read only", 32'h0000_0000, rd);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk("selector", 32'h0000_1234, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, 32'(serr));
    apb(1'b1, 8'h1c, 32'h0000_0003);
    $display("test registers done");
  endtask

  task automatic t_launch;
    logic [15:0] nums [8];
    nums = '{16'h0005, 16'h0258, 16'h1b58, 16'h1b5c, 16'h2329, 16'h232a, 16'h232b, 16'h232c};
    for (int i = 0; i < 8; i++) begin
      go(2'(i % 3), nums[i], psc_pkg::psc_kind_type'(i < 2 ? 0 : (i < 4 ? 1 : i - 2)), 1'b0);
      fin(1'b0, 16'h0000);
    end
    $display("test launch done");
  endtask

  task automatic t_errors;
    logic [15:0] bad [6];
    int c;
    bad = '{16'h0000, 16'h0259, 16'h1b57, 16'h1b5d, 16'h2328, 16'h232d};
    c = l_cnt;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h08, 32'(i < 6 ? bad[i] : 16'h0005));
      apb(1'b1, 8'h10, i < 6 ? 32'h0000_0001 : 32'h0000_0031);
      fin(1'b1, i < 6 ? 16'h1862 : 16'h1865);
      bad[0] = 16'h0000;
    end
    chk("no launch on error", c, l_cnt);
    $display("test errors done");
  endtask

  task automatic t_stop_idle;
    int c;
    mask = 2'h2;
    apb(1'b1, 8'h1c, 32'h0000_0002);
    go(2'h2, 16'h0064, psc_pkg::psc_kind_data, 1'b1);
    fin(1'b0, 16'h0000);
    c = l_cnt;
    module_ready_flag <= 1'b0;
    apb(1'b1, 8'h10, 32'h0000_0001);
    repeat (3 * SCAN) @(posedge clk);
    chk("launch while not ready", c, l_cnt);
    chk("done while not ready", 32'h0000_0000, 32'(completion_done));
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk("status not ready", 32'h0000_0001, rd);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("control axis", 32'h0000_0020, rd);
    module_ready_flag <= 1'b1;
    $display("test stop and not ready done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_launch();
    t_errors();
    t_stop_idle();
    results();
  end
endmodule // tb_positioning_start_command
